// ### rtl/afd_afc_avg.sv
// Purpose: Averages frequency measurements over one, two or four bit pairs
// Assumes: Measurements arrive as single-cycle pulses on the shared clock
// Notes:   Depth zero forces a zero offset and discards partial sums
`timescale 1ns/1ps
module afd_afc_avg
   import afd_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   afd_afc_if.avg    afc
);
   typedef struct packed {
      logic signed [FREQ_W+1:0] acc;   // Running sum, two guard bits for four pairs
      logic [1:0]               cnt;   // Pairs summed so far
      logic signed [FREQ_W-1:0] avg;   // Last average
      logic                     vld;   // New-average pulse
   } afd_avg_s;

   afd_avg_s q, d;
   logic signed [FREQ_W+1:0] sum;      // Sum including the current pair
   logic [1:0]               last;     // Count value of the final pair

   // Next state of the averager
   always_comb begin
      d    = q;
      d.vld = 1'b0;
      sum  = q.acc + (FREQ_W+2)'(afc.meas);
      last = (afc.depth == 2'd3) ? 2'd3 : ((afc.depth == 2'd2) ? 2'd1 : 2'd0);
      if (afc.depth == 2'd0) begin
         // Correction off: demodulator sees no offset
         d.acc = '0;
         d.cnt = '0;
         d.avg = '0;
      end else if (afc.meas_valid) begin
         if (q.cnt >= last) begin
            // Divide by 1, 2 or 4 pairs with an arithmetic shift
            unique case (afc.depth)
               2'd1:    d.avg = FREQ_W'(sum);
               2'd2:    d.avg = FREQ_W'(sum >>> 1);
               default: d.avg = FREQ_W'(sum >>> 2);
            endcase
            d.acc = '0;
            d.cnt = '0;
            d.vld = 1'b1;
         end else begin
            d.acc = sum;
            d.cnt = q.cnt + 2'd1;
         end
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign afc.offset       = q.avg;
   assign afc.offset_valid = q.vld;
endmodule

// ### rtl/afd_afc_if.sv
// Purpose: Carries averaging depth, frequency measurements and the averaged result
// Assumes: One clock shared by both ends
// Notes:   meas_valid marks one measured 0/1 bit pair
`timescale 1ns/1ps
interface afd_afc_if;
   import afd_pkg::*;
   logic [1:0]               depth;        // Averaging depth selector
   logic signed [FREQ_W-1:0] meas;         // Frequency measured over one bit pair
   logic                     meas_valid;   // One-cycle pulse per bit pair
   logic signed [FREQ_W-1:0] offset;       // Averaged offset to the demodulator
   logic                     offset_valid; // One-cycle pulse on each new average
   modport avg (input depth, input meas, input meas_valid, output offset, output offset_valid);
   modport user (output depth, output meas, output meas_valid, input offset, input offset_valid);
endinterface

// ### rtl/afd_pkg.sv
// Purpose: Shared constants for the frequency-correction and decimator block
// Assumes: 32-bit AXI4-Lite data, registers one aligned word each
// Notes:   Register indices are kept; byte address is four times the index
package afd_pkg;
   // Register indices and derived byte addresses
   localparam logic [7:0] FREQ_CORR_IDX     = 8'h0f;
   localparam logic [7:0] CHAN_FILT_IDX     = 8'h10;
   localparam logic [7:0] FREQ_CORR_ADDR    = 8'(FREQ_CORR_IDX * 4);
   localparam logic [7:0] CHAN_FILT_ADDR    = 8'(CHAN_FILT_IDX * 4);
   // Reset values: depth 2, exponent 1, mantissa 12; filter all zero
   localparam logic [7:0] FREQ_CORR_RST     = 8'h9c;
   localparam logic [7:0] CHAN_FILT_RST     = 8'h00;
   // Field positions of the correction control register
   localparam int         DEPTH_MSB         = 7;
   localparam int         DEPTH_LSB         = 6;
   localparam int         DEV_EXP_MSB       = 5;
   localparam int         DEV_EXP_LSB       = 4;
   localparam int         DEV_MANT_MSB      = 3;
   localparam int         DEV_MANT_LSB      = 0;
   // Field positions of the channel filter register
   localparam int         BYPASS_BIT        = 7;
   localparam int         SHIFT_MSB         = 6;
   localparam int         SHIFT_LSB         = 5;
   localparam int         DIV_MSB           = 4;
   localparam int         DIV_LSB           = 0;
   // Widths of the data paths
   localparam int         SAMP_W            = 12;
   localparam int         DEC_W             = 20;
   localparam int         FREQ_W            = 12;
   localparam int         SCALE_W           = 7;
   // Filter bandwidth at divisor one, in Hz; bandwidth is this over the divisor
   localparam int         BW_BASE_HZ        = 307200;
   // AXI responses
   localparam logic [1:0] RESP_OKAY         = 2'b00;
   localparam logic [1:0] RESP_SLVERR       = 2'b10;
endpackage

// ### rtl/afd_top.sv
// Purpose: AXI4-Lite controlled frequency-correction averager and channel decimator
// Assumes: Samples and measurements come from logic on the same clock
// Notes:   Decimator is a boxcar sum over the divisor; outputs are registered
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module afd_top
   import afd_pkg::*;
(
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Receive path
   input  wire logic signed [SAMP_W-1:0] samp_data,
   input  wire logic                     samp_valid,
   input  wire logic signed [FREQ_W-1:0] freq_meas,
   input  wire logic                     freq_meas_valid,
   output logic signed [DEC_W-1:0]       dec_data,
   output logic                          dec_clk,
   output logic signed [FREQ_W-1:0]      afc_offset,
   output logic                          afc_offset_valid,
   output logic [SCALE_W-1:0]            rx_dev_scale,
   output logic                          analog_filter_bypass
);
   typedef struct packed {
      logic [7:0]              freq_correction_ctrl; // Depth, exponent, mantissa
      logic [7:0]              channel_filter_ctrl;  // Bypass, shift, divisor
      logic                    awready;              // Address channel open
      logic                    wready;               // Data channel open
      logic                    aw_hold;              // Write address captured
      logic [7:0]              aw_addr;              // Captured write address
      logic                    w_hold;               // Write data captured
      logic [7:0]              w_data;               // Captured low byte
      logic                    w_strb0;              // Captured lane 0 enable
      logic                    bvalid;               // Write response pending
      logic [1:0]              bresp;                // Write response code
      logic                    arready;              // Read address open
      logic                    rvalid;               // Read data pending
      logic [1:0]              rresp;                // Read response code
      logic [31:0]             rdata;                // Read data
      logic signed [DEC_W-1:0] acc;                  // Decimator running sum
      logic [4:0]              cnt;                  // Samples in this period
      logic [4:0]              div_act;              // Divisor selector in use
      logic [1:0]              shift_act;            // Input shift in use
      logic signed [DEC_W-1:0] dec_data;             // Last decimated output
      logic                    dec_clk;              // Decimation strobe
      logic [SCALE_W-1:0]      dev_scale;            // Deviation scale
      logic                    bypass;               // Analog filter bypass
   } afd_top_s;

   afd_top_s q, d;
   logic signed [DEC_W-1:0] samp_sh;  // Shifted input sample
   logic signed [DEC_W-1:0] samp_sum; // Sum including current sample
   logic [4:0]              div_use;  // Divisor selector for this sample
   logic [1:0]              shift_use; // Input shift for this sample

   afd_afc_if afc_bus ();

   // Averager sees depth straight from the register
   assign afc_bus.depth      = q.freq_correction_ctrl[DEPTH_MSB:DEPTH_LSB];
   assign afc_bus.meas       = freq_meas;
   assign afc_bus.meas_valid = freq_meas_valid;

   afd_afc_avg u_avg (
      .aclk    (aclk),
      .aresetn (aresetn),
      .afc     (afc_bus)
   );

   // Next state: bus slave, decimator and deviation scale
   always_comb begin
      d          = q;
      d.dec_clk  = 1'b0;
      // An empty period takes the register as it stands; a started one keeps its own
      div_use    = (q.cnt == 5'd0) ? q.channel_filter_ctrl[DIV_MSB:DIV_LSB] : q.div_act;
      shift_use  = (q.cnt == 5'd0) ? q.channel_filter_ctrl[SHIFT_MSB:SHIFT_LSB] : q.shift_act;
      samp_sh    = DEC_W'(samp_data) <<< shift_use;
      samp_sum   = q.acc + samp_sh;

      // Write address and data are taken in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_hold = 1'b1;
         d.aw_addr = s_axi_awaddr;
         d.awready = 1'b0;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_hold  = 1'b1;
         d.w_data  = s_axi_wdata[7:0];
         d.w_strb0 = s_axi_wstrb[0];
         d.wready  = 1'b0;
      end
      // Both halves present: commit and respond
      if (q.aw_hold && q.w_hold && !q.bvalid) begin
         d.aw_hold = 1'b0;
         d.w_hold  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = RESP_OKAY;
         if (q.aw_addr == FREQ_CORR_ADDR) begin
            if (q.w_strb0) begin
               d.freq_correction_ctrl = q.w_data;
            end
         end else if (q.aw_addr == CHAN_FILT_ADDR) begin
            if (q.w_strb0) begin
               d.channel_filter_ctrl = q.w_data;
            end
         end else begin
            // Unmapped address: nothing stored
            d.bresp = RESP_SLVERR;
         end
      end
      // Response taken: reopen both channels
      if (q.bvalid && s_axi_bready) begin
         d.bvalid  = 1'b0;
         d.awready = 1'b1;
         d.wready  = 1'b1;
      end

      // Read: one cycle from address to data
      if (s_axi_arvalid && q.arready) begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rresp   = RESP_OKAY;
         if (s_axi_araddr == FREQ_CORR_ADDR) begin
            d.rdata = {24'h000000, q.freq_correction_ctrl};
         end else if (s_axi_araddr == CHAN_FILT_ADDR) begin
            d.rdata = {24'h000000, q.channel_filter_ctrl};
         end else begin
            d.rdata = 32'h00000000;
            d.rresp = RESP_SLVERR;
         end
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid  = 1'b0;
         d.arready = 1'b1;
      end

      // Boxcar decimator: sum div_act+1 shifted samples per output
      if (samp_valid) begin
         // Settings are latched per period, so no sum mixes two divisors
         d.div_act   = div_use;
         d.shift_act = shift_use;
         if (q.cnt >= div_use) begin
            d.dec_data = samp_sum;
            d.dec_clk  = 1'b1;
            d.acc      = '0;
            d.cnt      = '0;
         end else begin
            d.acc = samp_sum;
            d.cnt = q.cnt + 5'd1;
         end
      end

      // Scale in units of baud/24: mantissa shifted by exponent
      d.dev_scale = SCALE_W'(q.freq_correction_ctrl[DEV_MANT_MSB:DEV_MANT_LSB])
                    << q.freq_correction_ctrl[DEV_EXP_MSB:DEV_EXP_LSB];
      d.bypass    = q.channel_filter_ctrl[BYPASS_BIT];
   end

   // State register; divisor and shift start from the reset register value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q                      <= '0;
         q.freq_correction_ctrl <= FREQ_CORR_RST;
         q.channel_filter_ctrl  <= CHAN_FILT_RST;
         q.awready              <= 1'b1;
         q.wready               <= 1'b1;
         q.arready              <= 1'b1;
         q.div_act              <= CHAN_FILT_RST[DIV_MSB:DIV_LSB];
         q.shift_act            <= CHAN_FILT_RST[SHIFT_MSB:SHIFT_LSB];
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state flops
   assign s_axi_awready        = q.awready;
   assign s_axi_wready         = q.wready;
   assign s_axi_bvalid         = q.bvalid;
   assign s_axi_bresp          = q.bresp;
   assign s_axi_arready        = q.arready;
   assign s_axi_rvalid         = q.rvalid;
   assign s_axi_rresp          = q.rresp;
   assign s_axi_rdata          = q.rdata;
   assign dec_data             = q.dec_data;
   assign dec_clk              = q.dec_clk;
   assign afc_offset           = afc_bus.offset;
   assign afc_offset_valid     = afc_bus.offset_valid;
   assign rx_dev_scale         = q.dev_scale;
   assign analog_filter_bypass = q.bypass;
endmodule

// ### verification/afd_checker.sv
// Purpose: Port-level assertions for the correction averager and channel decimator
// Assumes: Register writes are spaced from measurement and sample bursts
// Notes:   Shadow registers follow the bus one edge behind the design copy
`timescale 1ns/1ps
module afd_checker
   import afd_pkg::*;
(
   input wire logic                     aclk,
   input wire logic                     aresetn,
   input wire logic [7:0]               s_axi_awaddr,
   input wire logic                     s_axi_awvalid,
   input wire logic                     s_axi_awready,
   input wire logic [31:0]              s_axi_wdata,
   input wire logic [3:0]               s_axi_wstrb,
   input wire logic                     s_axi_wvalid,
   input wire logic                     s_axi_wready,
   input wire logic [1:0]               s_axi_bresp,
   input wire logic                     s_axi_bvalid,
   input wire logic signed [SAMP_W-1:0] samp_data,
   input wire logic                     samp_valid,
   input wire logic                     freq_meas_valid,
   input wire logic signed [DEC_W-1:0]  dec_data,
   input wire logic                     dec_clk,
   input wire logic signed [FREQ_W-1:0] afc_offset,
   input wire logic                     afc_offset_valid,
   input wire logic [SCALE_W-1:0]       rx_dev_scale,
   input wire logic                     analog_filter_bypass
);
   logic [7:0] aa_q;   // Captured write address
   logic [8:0] wd_q;   // Strobe lane 0 and data byte
   logic       bv_q;   // Previous write response valid
   logic [7:0] corr_q; // Shadow of the correction control register
   logic [7:0] filt_q; // Shadow of the channel filter register
   logic [2:0] mc_q;   // Measurements since the last average
   logic [5:0] sc_q;   // Samples since the last decimated output
   // Shadow update on a fresh OKAY response; counters restart on each result
   always_ff @(posedge aclk) begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      if (s_axi_bvalid && !bv_q && s_axi_bresp == RESP_OKAY && wd_q[8]) begin
         if (aa_q == FREQ_CORR_ADDR) corr_q <= wd_q[7:0];
         if (aa_q == CHAN_FILT_ADDR) filt_q <= wd_q[7:0];
      end
      // Depth zero throws away any partial sum
      mc_q <= (corr_q[7:6] == 2'd0) ? 3'd0 :
              afc_offset_valid ? 3'(freq_meas_valid) : mc_q + 3'(freq_meas_valid);
      sc_q <= dec_clk ? 6'(samp_valid) : sc_q + 6'(samp_valid);
      if (!aresetn) begin
         corr_q <= FREQ_CORR_RST;
         filt_q <= CHAN_FILT_RST;
         mc_q   <= 3'd0;
         sc_q   <= 6'd0;
         bv_q   <= 1'b0;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_BYPASS: assert property (analog_filter_bypass == filt_q[7])
      else $error("bypass output differs from register bit");
   AST_SCALE: assert property ($past(aresetn, 2) |->
      rx_dev_scale == (SCALE_W'(corr_q[3:0]) << corr_q[5:4]))
      else $error("deviation scale differs from mantissa and exponent");
   AST_AFC_OFF: assert property (corr_q[7:6] == 2'd0 && $past(corr_q[7:6]) == 2'd0 |->
      afc_offset == '0 && !afc_offset_valid)
      else $error("offset not zero with averaging off");
   AST_AFC_CNT: assert property (afc_offset_valid |->
      mc_q == ((corr_q[7:6] == 2'd3) ? 3'd4 : 3'(corr_q[7:6])))
      else $error("average issued after wrong measurement count");
   AST_DEC_CNT: assert property (dec_clk |-> sc_q == 6'(filt_q[4:0]) + 6'd1)
      else $error("decimated output after wrong sample count");
   AST_DEC_ONE: assert property (dec_clk && filt_q[4:0] == 5'd0 && $past(samp_valid) |->
      dec_data == (DEC_W'($past(samp_data)) <<< filt_q[6:5]))
      else $error("single sample output not shifted as set");
   AST_DEC_HOLD: assert property (!dec_clk && $past(aresetn) |-> $stable(dec_data))
      else $error("decimated data moved between outputs");
   AST_AFC_HOLD: assert property (!afc_offset_valid && corr_q[7:6] != 2'd0 && $past(aresetn)
      |-> $stable(afc_offset))
      else $error("offset moved without a new average");
   // Main scenarios reached
   cover property (dec_clk && filt_q[4:0] == 5'd31);
   cover property (afc_offset_valid && corr_q[7:6] == 2'd3);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

// ### verification/test_afc_and_channel_decimator_cfg.sv
// Purpose: Self-checking bench for the correction averager and channel decimator
// Assumes: Bench is sole bus master and source of samples and measurements
// Notes:   Pulse and bus results are queued by the driver and matched by a monitor; levels are checked inline
`timescale 1ns/1ps
module test_afc_and_channel_decimator_cfg
   import afd_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, samp_valid, freq_meas_valid, dec_clk, afc_offset_valid, bypass;
   logic [7:0]               s_axi_awaddr, s_axi_araddr, v;
   logic [31:0]              s_axi_wdata, s_axi_rdata;
   logic [3:0]               s_axi_wstrb;
   logic [1:0]               s_axi_bresp, s_axi_rresp;
   logic signed [SAMP_W-1:0] samp_data, smp[32];
   logic signed [FREQ_W-1:0] freq_meas, afc_offset, mq[4];
   logic signed [DEC_W-1:0]  dec_data;
   logic [SCALE_W-1:0]       rx_dev_scale;
   logic [31:0]              dq[$], aq[$], rq[$], bq[$]; // Expected results, oldest first
   int                       mismatches, cmp_count, seed, i, k, d, s, n;
   afd_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .samp_data(samp_data),
      .samp_valid(samp_valid), .freq_meas(freq_meas), .freq_meas_valid(freq_meas_valid),
      .dec_data(dec_data), .dec_clk(dec_clk), .afc_offset(afc_offset),
      .afc_offset_valid(afc_offset_valid), .rx_dev_scale(rx_dev_scale),
      .analog_filter_bypass(bypass));
   // Clock at 20 MHz
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One compare per kind of result, all counted in check
   task automatic check_dec(input logic [31:0] got, input logic [31:0] exp);
      check(got, exp);
   endtask
   task automatic check_afc(input logic [31:0] got, input logic [31:0] exp);
      check(got, exp);
   endtask
   task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
      check(got, exp);
   endtask
   task automatic check_resp(input logic [31:0] got, input logic [31:0] exp);
      check(got, exp);
   endtask
   task automatic check_level(input logic [31:0] got, input logic [31:0] exp);
      check(got, exp);
   endtask
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
      bq.push_back(32'(er));
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b0;
      end while (s_axi_bready);
   endtask
   // Read: data is matched by the monitor at the handshake edge
   task automatic rd(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
      rq.push_back({er, dat[29:0]});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b0;
      end while (s_axi_rready);
   endtask
   // Monitor: an empty queue yields x, so a surplus result never matches
   always @(posedge aclk) begin
      if (aresetn && dec_clk) check_dec(32'(dec_data), dq.size() ? dq.pop_front() : 'x);
      if (aresetn && afc_offset_valid)
         check_afc(32'(afc_offset), aq.size() ? aq.pop_front() : 'x);
      if (aresetn && s_axi_rvalid && s_axi_rready)
         check_read({s_axi_rresp, s_axi_rdata[29:0]}, rq.size() ? rq.pop_front() : 'x);
      if (aresetn && s_axi_bvalid && s_axi_bready)
         check_resp(32'(s_axi_bresp), bq.size() ? bq.pop_front() : 'x);
   end
   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      complete_run;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {samp_valid, freq_meas_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      samp_data = '0;
      freq_meas = '0;
      s_axi_wstrb = 4'h1;
      seed = 32'h72d4;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(FREQ_CORR_ADDR, 32'(FREQ_CORR_RST), RESP_OKAY);
      rd(CHAN_FILT_ADDR, 32'(CHAN_FILT_RST), RESP_OKAY);
      rd(8'h44, 32'h0, RESP_SLVERR);
      wr(8'h44, 32'hff, RESP_SLVERR);
      check_level(32'(rx_dev_scale), 32'(FREQ_CORR_RST[3:0]) << FREQ_CORR_RST[5:4]);
      // Lane 0 strobe clear must leave the register untouched
      s_axi_wstrb <= 4'h0;
      wr(CHAN_FILT_ADDR, 32'hff, RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      rd(CHAN_FILT_ADDR, 32'h0, RESP_OKAY);
      // Divisors 1, 6, 31 and 32; shift and bypass picked as software is advised
      for (i = 0; i < 4; i++) begin
         d = (i == 0) ? 0 : ((i == 1) ? 5 : 28 + i);
         v = {1'(d < 2), 2'((d <= 1) ? 0 : ((d < 24) ? 1 : 2)), 5'(d)};
         wr(CHAN_FILT_ADDR, 32'(v), RESP_OKAY);
         rd(CHAN_FILT_ADDR, 32'(v), RESP_OKAY);
         check_level(32'(bypass), 32'(v[7]));
         s = 0;
         for (k = 0; k <= d; k++) begin
            smp[k] = SAMP_W'($random(seed));
            s += int'(smp[k]) * (1 << v[6:5]);
         end
         dq.push_back(32'(DEC_W'(s)));
         for (k = 0; k <= d; k++) begin
            @(posedge aclk);
            samp_data <= smp[k];
            samp_valid <= 1'b1;
         end
         @(posedge aclk);
         samp_valid <= 1'b0;
      end
      // Depths 3 down to 0, the advised deepest first; mantissa kept within 8 to 15
      for (d = 3; d >= 0; d--) begin
         v = {2'(d), 2'($random(seed)), 1'b1, 3'($random(seed))};
         wr(FREQ_CORR_ADDR, 32'(v), RESP_OKAY);
         rd(FREQ_CORR_ADDR, 32'(v), RESP_OKAY);
         check_level(32'(rx_dev_scale), 32'(v[3:0]) << v[5:4]);
         n = (d == 3) ? 4 : d;
         s = 0;
         for (k = 0; k < 4; k++) begin
            mq[k] = FREQ_W'($random(seed) % 512);
            s += int'(mq[k]);
            if (n != 0 && (k + 1) % n == 0) begin
               aq.push_back(32'(FREQ_W'(s >>> (d - 1))));
               s = 0;
            end
         end
         for (k = 0; k < 4; k++) begin
            @(posedge aclk);
            freq_meas <= mq[k];
            freq_meas_valid <= 1'b1;
         end
         @(posedge aclk);
         freq_meas_valid <= 1'b0;
         repeat (3) @(posedge aclk);
      end
      check_level(32'(afc_offset), 32'h0);
      repeat (4) @(posedge aclk);
      check_level(32'(dq.size() + aq.size() + rq.size() + bq.size()), 32'h0);
      complete_run;
   end
endmodule
bind afd_top afd_checker chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .samp_data(samp_data),
   .samp_valid(samp_valid), .freq_meas_valid(freq_meas_valid), .dec_data(dec_data),
   .dec_clk(dec_clk), .afc_offset(afc_offset), .afc_offset_valid(afc_offset_valid),
   .rx_dev_scale(rx_dev_scale), .analog_filter_bypass(analog_filter_bypass));
